//--- rtl/pbcd_port_data.sv
// Purpose: data registers and mode registers of ports B, C and D on classic Wishbone
// Assumes: pin inputs are synchronous to sys_clk; rstn is the power-on reset
// Notes: ack comes one cycle after the request; data registers are one byte wide
`timescale 1ns/1ps
`default_nettype none
module pbcd_port_data
	import pbcd_pkg::*;
(
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic rstn,
	// manual reset and standby, both leave the data registers alone
	input wire logic manual_rst_n,
	input wire logic standby,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// port B pins
	input wire logic [7:0] port_b_pin_in,
	output logic [7:0] port_b_pin_out,
	output logic [7:0] port_b_pin_oe_n,
	output logic [7:0] port_b_pullup_en,
	// port C pins
	input wire logic [7:0] port_c_pin_in,
	output logic [7:0] port_c_pin_out,
	output logic [7:0] port_c_pin_oe_n,
	output logic [7:0] port_c_pullup_en,
	// port D pins
	input wire logic [7:0] port_d_pin_in,
	output logic [7:0] port_d_pin_out,
	output logic [7:0] port_d_pin_oe_n,
	output logic [7:0] port_d_pullup_en
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [23:0] data_ff, nxt_data;
	logic [47:0] mode_ff, nxt_mode;
	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;

	logic [23:0] pin_level, read_bits, write_ok, drive, pull_up;
	logic [11:0] idx;
	logic req;
	logic wr_fire;

	assign pin_level = {port_d_pin_in, port_c_pin_in, port_b_pin_in};
	assign idx = wb_adr_i[13:2];
	// standby holds new requests off; the master simply waits
	assign req = wb_cyc_i && wb_stb_i && !ack_ff && !standby;
	assign wr_fire = ack_ff && wb_cyc_i && wb_stb_i && wb_we_i;

	// ---------------------------------------------------------------
	// per-pin decode
	// ---------------------------------------------------------------
	// one cell per pin; its kind fixes which mode codes are legal
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
			pbcd_pin_cell #(
				.KIND(PIN_KIND[3*i +: 3])
			) u_cell (
				.mode(mode_ff[2*i +: 2]),
				.data_bit(data_ff[i]),
				.pin_level(pin_level[i]),
				.read_bit(read_bits[i]),
				.write_ok(write_ok[i]),
				.drive(drive[i]),
				.pull_up(pull_up[i])
			);
		end
	endgenerate

	// pin data straight from the register; enable low only in output mode
	assign port_b_pin_out = data_ff[7:0];
	assign port_c_pin_out = data_ff[15:8];
	assign port_d_pin_out = data_ff[23:16];
	assign port_b_pin_oe_n = ~drive[7:0];
	assign port_c_pin_oe_n = ~drive[15:8];
	assign port_d_pin_oe_n = ~drive[23:16];
	assign port_b_pullup_en = pull_up[7:0];
	assign port_c_pullup_en = pull_up[15:8];
	assign port_d_pullup_en = pull_up[23:16];

	// ---------------------------------------------------------------
	// bus handshake and read data
	// ---------------------------------------------------------------
	// read data is captured with the ack so it is stable for the master's sample
	always_comb begin
		nxt_ack = req && manual_rst_n;
		nxt_rdat = 32'h0000_0000;
		if (req) begin
			case (idx)
				IDX_B_DATA: nxt_rdat = {24'h00_0000, read_bits[7:0]};
				IDX_C_DATA: nxt_rdat = {24'h00_0000, read_bits[15:8]};
				IDX_D_DATA: nxt_rdat = {24'h00_0000, read_bits[23:16]};
				IDX_B_MODE: nxt_rdat = {16'h0000, mode_ff[15:0]};
				IDX_C_MODE: nxt_rdat = {16'h0000, mode_ff[31:16]};
				IDX_D_MODE: nxt_rdat = {16'h0000, mode_ff[47:32]};
				default: nxt_rdat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	// only byte lane 0 reaches a data register; other lanes are dropped
	always_comb begin
		nxt_data = data_ff;
		nxt_mode = mode_ff;
		if (wr_fire) begin
			case (idx)
				IDX_B_DATA: if (wb_sel_i[0]) begin
					nxt_data[7:0] = (wb_dat_i[7:0] & write_ok[7:0]) |
						(data_ff[7:0] & ~write_ok[7:0]);
				end
				IDX_C_DATA: if (wb_sel_i[0]) begin
					nxt_data[15:8] = (wb_dat_i[7:0] & write_ok[15:8]) |
						(data_ff[15:8] & ~write_ok[15:8]);
				end
				IDX_D_DATA: if (wb_sel_i[0]) begin
					nxt_data[23:16] = (wb_dat_i[7:0] & write_ok[23:16]) |
						(data_ff[23:16] & ~write_ok[23:16]);
				end
				IDX_B_MODE: begin
					if (wb_sel_i[0]) nxt_mode[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) nxt_mode[15:8] = wb_dat_i[15:8];
				end
				IDX_C_MODE: begin
					if (wb_sel_i[0]) nxt_mode[23:16] = wb_dat_i[7:0];
					if (wb_sel_i[1]) nxt_mode[31:24] = wb_dat_i[15:8];
				end
				IDX_D_MODE: begin
					if (wb_sel_i[0]) nxt_mode[39:32] = wb_dat_i[7:0];
					if (wb_sel_i[1]) nxt_mode[47:40] = wb_dat_i[15:8];
				end
				default: nxt_data = data_ff;
			endcase
		end
	end

	// only the power-on reset clears; manual reset and standby never touch these
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			data_ff <= {DATA_RESET, DATA_RESET, DATA_RESET};
			mode_ff <= {D_MODE_RESET, C_MODE_RESET, B_MODE_RESET};
		end else begin
			data_ff <= nxt_data;
			mode_ff <= nxt_mode;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_request;
		wb_cyc_i && wb_stb_i && !ack_ff && !standby && manual_rst_n;
	endsequence
	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_read_b;
		wb_ack_o && !wb_we_i && idx == IDX_B_DATA;
	endsequence

	a_ack_one_shot: assert property (s_request |=> s_answer)
		else $error("ack not a single pulse one cycle after request");

	a_por_clear: assert property ($rose(rstn) |-> data_ff == 24'h00_0000)
		else $error("data registers not zero after power-on reset");

	a_upper_c_input: assert property ($rose(rstn) |-> mode_ff[31:24] == 8'haa)
		else $error("port C upper pins not pulled-up inputs after reset");

	a_b_write_store: assert property (wr_fire && idx == IDX_B_DATA && wb_sel_i[0]
		|=> port_b_pin_out == $past(wb_dat_i[7:0]))
		else $error("port B write not stored");

	a_data_hold: assert property (!wr_fire |=> $stable(data_ff))
		else $error("data register changed without a write");

	a_out_reads_reg: assert property (s_read_b and mode_ff[1:0] == MODE_OUTPUT
		|-> wb_dat_o[0] == data_ff[0])
		else $error("output pin did not read stored bit");

	a_in_reads_pin: assert property (s_read_b and mode_ff[1]
		|-> wb_dat_o[0] == $past(port_b_pin_in[0]))
		else $error("input pin did not read pin level");

	a_no_drive_off: assert property (mode_ff[1:0] != MODE_OUTPUT
		|-> port_b_pin_oe_n[0] ##1 (mode_ff[1:0] != MODE_OUTPUT || !port_b_pin_oe_n[0]))
		else $error("pin driven outside output mode");

	a_c_reserved_low: assert property (wb_ack_o && !wb_we_i && idx == IDX_C_DATA
		&& mode_ff[17] |-> !wb_dat_o[0] && port_c_pin_oe_n[0])
		else $error("port C pin 0 reserved mode not read low");

	a_c1_dead_mode: assert property (wr_fire && idx == IDX_C_DATA
		&& mode_ff[19:18] == MODE_OUTPUT |=> $stable(data_ff[9]))
		else $error("port C pin 1 reserved mode accepted a write");

	a_d_input_only: assert property (data_ff[20] == 1'b0 && data_ff[22] == 1'b0)
		else $error("port D input-only bit stored a value");

endmodule : pbcd_port_data
`default_nettype wire

//--- rtl/pbcd_pkg.sv
// Purpose: constants for the port B/C/D pin data registers
// Assumes: classic Wishbone, 32-bit data, byte address = 4 * register index
// Notes: one pin kind per port bit, packed into a table below
//
// How it works
// - port B has one 8-bit data register, bit n for pin n, readable and writable.
// - a pin in output mode reads back its stored data bit, not the pin level.
// - a pin in either input mode reads back the level sampled on the pin.
// - power-on reset clears every port data register to zero.
// - manual reset and standby leave every port data register unchanged.
// - a full two-way pin decodes mode 00 peripheral, 01 output, 10 input pulled up, 11 input.
// - in peripheral and input modes a write stores the bit but never drives the pin.
// - port C has two-way pins 4 to 7, output-only pins 0, 2, 3 and input-only pin 1.
// - on port C pins 0, 2, 3 a mode with its upper bit set reads low and drops writes.
// - port C pin 1 stores in mode 00, is dead in mode 01, and is an input in modes 1x.
// - after power-on reset port C pins 4 to 7 are pulled-up inputs and read the pins.
// - port D has six two-way and two input-only pins and resets to zero.
// - port D bits 4 and 6 read low outside input mode and ignore writes.
package pbcd_pkg;

	// ---------------------------------------------------------------
	// register map (index = printed offset, low 12 bits)
	// ---------------------------------------------------------------
	localparam logic [31:0] PORT_B_PIN_DATA_ADDR = 32'ha4000122;
	localparam logic [31:0] PORT_C_PIN_DATA_ADDR = 32'ha4000124;
	localparam logic [31:0] PORT_D_PIN_DATA_ADDR = 32'ha4000126;
	localparam logic [11:0] IDX_B_DATA = PORT_B_PIN_DATA_ADDR[11:0];
	localparam logic [11:0] IDX_C_DATA = PORT_C_PIN_DATA_ADDR[11:0];
	localparam logic [11:0] IDX_D_DATA = PORT_D_PIN_DATA_ADDR[11:0];
	localparam logic [11:0] IDX_B_MODE = 12'h102;
	localparam logic [11:0] IDX_C_MODE = 12'h104;
	localparam logic [11:0] IDX_D_MODE = 12'h106;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [15:0] B_MODE_RESET = 16'h0000;
	localparam logic [15:0] C_MODE_RESET = 16'haa00;
	localparam logic [15:0] D_MODE_RESET = 16'h0000;

	// ---------------------------------------------------------------
	// mode codes and pin kinds
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_PERIPH = 2'h0;
	localparam logic [1:0] MODE_OUTPUT = 2'h1;
	localparam logic [1:0] MODE_IN_PULL = 2'h2;
	localparam logic [1:0] MODE_IN_FLOAT = 2'h3;

	localparam logic [2:0] KIND_BIDIR = 3'h0;
	localparam logic [2:0] KIND_OUT_ONLY = 3'h1;
	localparam logic [2:0] KIND_IN_STORE = 3'h2;
	localparam logic [2:0] KIND_BIDIR_NOPU = 3'h3;
	localparam logic [2:0] KIND_IN_ONLY = 3'h4;

	localparam int NUM_PINS = 24;
	// kind of pin i sits at [3*i +: 3]; bits 23..16 port D, 15..8 port C, 7..0 port B
	localparam logic [71:0] PIN_KIND = {
		3'h3, 3'h4, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h1,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};

endpackage : pbcd_pkg

//--- rtl/pbcd_pin_cell.sv
// Purpose: per-pin mode decode for read source, write permission, drive and pull-up
// Assumes: pin level is synchronous to the system clock
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module pbcd_pin_cell
	import pbcd_pkg::*;
#(
	parameter logic [2:0] KIND = 3'h0
) (
	// mode and state
	input wire logic [1:0] mode,
	input wire logic data_bit,
	input wire logic pin_level,
	// decoded controls
	output logic read_bit,
	output logic write_ok,
	output logic drive,
	output logic pull_up
);

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// reserved codes read low and drop writes so a stray setting cannot drive a pin
	always_comb begin
		read_bit = 1'b0;
		write_ok = 1'b0;
		drive = 1'b0;
		pull_up = 1'b0;
		case (KIND)
			KIND_BIDIR, KIND_BIDIR_NOPU: begin
				write_ok = 1'b1;
				if (mode[1]) begin
					read_bit = pin_level;
					pull_up = (mode == MODE_IN_PULL) && (KIND == KIND_BIDIR);
				end else begin
					read_bit = data_bit;
					drive = (mode == MODE_OUTPUT);
				end
			end
			KIND_OUT_ONLY: begin
				if (!mode[1]) begin
					read_bit = data_bit;
					write_ok = 1'b1;
					drive = (mode == MODE_OUTPUT);
				end
			end
			KIND_IN_STORE: begin
				case (mode)
					MODE_PERIPH: begin
						read_bit = data_bit;
						write_ok = 1'b1;
					end
					MODE_IN_PULL: begin
						read_bit = pin_level;
						write_ok = 1'b1;
						pull_up = 1'b1;
					end
					MODE_IN_FLOAT: begin
						read_bit = pin_level;
						write_ok = 1'b1;
					end
					default: begin
						read_bit = 1'b0;
					end
				endcase
			end
			KIND_IN_ONLY: begin
				// never writable, so its stored bit stays at reset zero
				read_bit = mode[1] & pin_level;
				pull_up = (mode == MODE_IN_PULL);
			end
			default: begin
				read_bit = 1'b0;
			end
		endcase
	end

endmodule : pbcd_pin_cell
`default_nettype wire

//--- dv/pbcd_pin_world.sv
// Purpose: external circuitry on one 8-bit port
// Assumes: the bench may leave ext_en raised on pins the block drives; block drive wins
// Notes: an unpulled, undriven pin toggles each cycle so no stale level reads back
`timescale 1ns/1ps
`default_nettype none
module pbcd_pin_world (
	// clock
	input wire logic sys_clk,
	// block side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pullup_en,
	// bench side
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] level
);
	logic flip_ff = 1'b0;

	// a floating wire is undefined, so make it wander
	always_ff @(posedge sys_clk) begin
		flip_ff <= ~flip_ff;
	end

	// block drive wins, then the outside driver, then the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			level[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pullup_en[i] ? 1'b1 : flip_ff;
		end
	end
endmodule : pbcd_pin_world
`default_nettype wire

//--- dv/pbcd_port_data_tb.sv
// Purpose: self-checking bench for the port B/C/D data registers
// Assumes: ack within a few cycles of each request
// Notes: reserved modes are set on purpose only to see them refused
`timescale 1ns/1ps
`default_nettype none
module pbcd_port_data_tb;
	import pbcd_pkg::*;
	logic sys_clk, rstn, manual_rst_n, standby, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	logic [7:0] pin [3];
	logic [7:0] pout [3];
	logic [7:0] oe_n [3];
	logic [7:0] pu [3];
	logic [7:0] xen [3];
	logic [7:0] xval [3];
	int n_mismatch = 0;
	int checks_done = 0;

	pbcd_port_data i_dut (.sys_clk(sys_clk), .rstn(rstn), .manual_rst_n(manual_rst_n),
		.standby(standby), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .port_b_pin_in(pin[0]), .port_b_pin_out(pout[0]),
		.port_b_pin_oe_n(oe_n[0]), .port_b_pullup_en(pu[0]), .port_c_pin_in(pin[1]),
		.port_c_pin_out(pout[1]), .port_c_pin_oe_n(oe_n[1]), .port_c_pullup_en(pu[1]),
		.port_d_pin_in(pin[2]), .port_d_pin_out(pout[2]), .port_d_pin_oe_n(oe_n[2]),
		.port_d_pullup_en(pu[2]));

	// one outside world per port
	for (genvar p = 0; p < 3; p++) begin : g_world
		pbcd_pin_world i_world (.sys_clk(sys_clk), .pin_out(pout[p]), .pin_oe_n(oe_n[p]),
			.pullup_en(pu[p]), .ext_en(xen[p]), .ext_val(xval[p]), .level(pin[p]));
	end

	// -------------------------------------------------------------
	// clock, compare and bus tasks
	// -------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// classic single cycle; ack is sampled at the rising edge, the same edge the write lands on
	task automatic wb(input logic we, input logic [11:0] idx, input logic [31:0] dat,
		input logic [3:0] sel, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		wb_adr_i <= {18'h0, idx, 2'h0};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk({31'h0, wb_ack_o}, 32'h1, "bus ack");
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [11:0] idx, input logic [31:0] dat);
		logic [31:0] q;
		wb(1'b1, idx, dat, 4'hf, q);
	endtask : wr

	task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] q;
		wb(1'b0, idx, 32'h0, 4'hf, q);
		chk(q, exp, what);
	endtask : rdc

	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic t_port_b;
		logic [31:0] q;
		wr(IDX_B_MODE, 32'h5555);
		wr(IDX_B_DATA, 32'ha5);
		rdc(IDX_B_DATA, 32'ha5, "b output read");
		chk({16'h0, oe_n[0], pout[0]}, 32'h00a5, "b drive");
		xen[0] <= 8'hff;
		xval[0] <= 8'h3c;
		wr(IDX_B_MODE, 32'haaaa);
		wr(IDX_B_DATA, 32'h5a);
		rdc(IDX_B_DATA, 32'h3c, "b pulled input");
		chk({8'h0, pu[0], oe_n[0], pout[0]}, 32'hffff5a, "b input pins");
		wr(IDX_B_MODE, 32'hffff);
		rdc(IDX_B_DATA, 32'h3c, "b plain input");
		chk({24'h0, pu[0]}, 32'h0, "b pull-up off");
		wr(IDX_B_MODE, 32'h0);
		wb(1'b1, IDX_B_DATA, 32'hff, 4'he, q);
		rdc(IDX_B_DATA, 32'h5a, "b peripheral read");
		chk({24'h0, oe_n[0]}, 32'hff, "b peripheral no drive");
		$display("test port_b done");
	endtask : t_port_b

	task automatic t_port_c;
		// reserved codes on the three outputs and the input, only to see them refused
		wr(IDX_C_MODE, 32'h55f7);
		wr(IDX_C_DATA, 32'hff);
		rdc(IDX_C_DATA, 32'hf0, "c reserved read");
		chk({16'h0, oe_n[1], pout[1]}, 32'h0ff0, "c reserved pins");
		wr(IDX_C_MODE, 32'h5555);
		rdc(IDX_C_DATA, 32'hf0, "c dropped writes");
		chk({24'h0, oe_n[1]}, 32'h02, "c input-only never drives");
		wr(IDX_C_MODE, 32'h0);
		wr(IDX_C_DATA, 32'h02);
		rdc(IDX_C_DATA, 32'h02, "c pin1 stored");
		xen[1] <= 8'h02;
		xval[1] <= 8'h00;
		wr(IDX_C_MODE, 32'h0008);
		rdc(IDX_C_DATA, 32'h00, "c pin1 input");
		$display("test port_c done");
	endtask : t_port_c

	task automatic t_port_d;
		wr(IDX_D_MODE, 32'h0);
		wr(IDX_D_DATA, 32'hff);
		rdc(IDX_D_DATA, 32'haf, "d read-only bits");
		xen[2] <= 8'hff;
		xval[2] <= 8'h5a;
		wr(IDX_D_MODE, 32'haaaa);
		rdc(IDX_D_DATA, 32'h5a, "d input");
		chk({24'h0, pu[2]}, 32'h5f, "d pull-ups");
		wr(IDX_D_MODE, 32'h5555);
		rdc(IDX_D_DATA, 32'haf, "d output");
		chk({24'h0, oe_n[2]}, 32'h50, "d drive");
		$display("test port_d done");
	endtask : t_port_d

	task automatic t_keep;
		wr(IDX_B_DATA, 32'h96);
		manual_rst_n <= 1'b0;
		standby <= 1'b1;
		@(posedge sys_clk);
		// a request held through standby and manual reset must not be answered
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= 1'b0;
		wb_adr_i <= {18'h0, IDX_B_DATA, 2'h0};
		repeat (3) begin
			@(posedge sys_clk);
			chk({31'h0, wb_ack_o}, 32'h0, "ack while held off");
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		manual_rst_n <= 1'b1;
		standby <= 1'b0;
		rdc(IDX_B_DATA, 32'h96, "b kept");
		rdc(12'h3ff, 32'h0, "unmapped");
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		xen[1] <= 8'h0;
		rdc(IDX_B_DATA, 32'h0, "b cleared");
		rdc(IDX_D_DATA, 32'h0, "d cleared");
		rdc(IDX_C_DATA, 32'hf0, "c upper pulled");
		chk({24'h0, pu[1]}, 32'hf0, "c pull-ups");
		$display("test keep done");
	endtask : t_keep

	// -------------------------------------------------------------
	// run control
	// -------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	// tests need a little over a hundred cycles
	initial begin
		repeat (4000) @(posedge sys_clk);
		n_mismatch++;
		$display("FAIL t=%0t watchdog", $time);
		close_out();
	end

	initial begin
		{rstn, manual_rst_n, standby, wb_cyc_i, wb_stb_i, wb_we_i} = 6'b010000;
		{wb_adr_i, wb_dat_i, wb_sel_i} = 68'h0;
		foreach (xen[p]) begin
			xen[p] = 8'h0;
			xval[p] = 8'h0;
		end
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_port_b();
		t_port_c();
		t_port_d();
		t_keep();
		close_out();
	end
endmodule : pbcd_port_data_tb
`default_nettype wire
